/* rtl/ccfg_pkg.sv */
/*
 Constants, field layout and decode types for the channel function and
 converter setup register pair. Assumes a 16-bit register port with a
 7-bit word address behind the serial interface, on one clock.
*/
// Function
// - Channel function field resets to high impedance code 0000.
// - Undefined or reserved function codes behave as high impedance.
// - Function codes 0001 to 1001 select the nine listed channel functions.
// - Writing function select may update fields in dependent setup registers.
// - Converter stays operational while high impedance is selected.
// - Second rate field 15:13 resets 001; unlisted codes give 20 SPS.
// - First rate field 12:10 resets 001, same decode and fallback.
// - Only 10 SPS and 20 SPS give 50 Hz and 60 Hz rejection.
// - Second range field 9:7 resets 000; unlisted codes give 0 to 12 V.
// - Range codes 000 to 101 select the six listed input ranges.
// - Converter setup register sits at 0x02, resets to 0x2400.
package ccfg_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam logic [6:0] FUNC_SEL_ADDR = 7'h01;
   localparam logic [6:0] CONV_SETUP_ADDR = 7'h02;
   localparam logic [15:0] FUNC_RESET = 16'h0000;
   localparam logic [15:0] CONV_RESET = 16'h2400;
   localparam logic [15:0] READ_IDLE = 16'h0000;
   localparam int FUNC_LSB = 0;
   localparam int FUNC_W = 4;
   localparam int RATE2_LSB = 13;
   localparam int RATE1_LSB = 10;
   localparam int RANGE2_LSB = 7;
   localparam int RATE_W = 3;
   localparam int RANGE_W = 3;
   localparam int LOW_LSB = 0;
   localparam int LOW_W = 7;
   localparam int RSVD_W = DATA_W - FUNC_W;
   localparam logic [RSVD_W-1:0] RSVD_ZERO = 12'h000;

   typedef enum logic [3:0] {
      FUNC_HIGH_Z = 4'h0,
      FUNC_VOUT = 4'h1,
      FUNC_IOUT = 4'h2,
      FUNC_VIN = 4'h3,
      FUNC_IIN_EXT = 4'h4,
      FUNC_IIN_LOOP = 4'h5,
      FUNC_RES_2W = 4'h6,
      FUNC_RES_34W = 4'h7,
      FUNC_DIN_LOGIC = 4'h8,
      FUNC_DIN_LOOP = 4'h9
   } ccfg_func_t;

   typedef enum logic [2:0] {
      RATE_10 = 3'h0,
      RATE_20 = 3'h1,
      RATE_1K2 = 3'h2,
      RATE_4K8 = 3'h3,
      RATE_9K6 = 3'h4
   } ccfg_rate_t;

   typedef enum logic [2:0] {
      RANGE_0_12V = 3'h0,
      RANGE_PM12V = 3'h1,
      RANGE_PM2V5 = 3'h2,
      RANGE_N2V5_0 = 3'h3,
      RANGE_0_2V5 = 3'h4,
      RANGE_0_0V625 = 3'h5
   } ccfg_range_t;
endpackage

/* rtl/ccfg_rate_dec.sv */
/*
 Conversion rate decoder: raw 3-bit rate code to effective rate and
 mains rejection flag. Purely combinational, fed from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ccfg_rate_dec
   import ccfg_pkg::*;
(
   // Raw field
   input wire logic [ccfg_pkg::RATE_W-1:0] rate_code,
   // Decoded
   output ccfg_pkg::ccfg_rate_t rate_eff,
   output logic line_reject
);
   always_comb begin
      case (rate_code)
         RATE_10: rate_eff = RATE_10;
         RATE_20: rate_eff = RATE_20;
         RATE_1K2: rate_eff = RATE_1K2;
         RATE_4K8: rate_eff = RATE_4K8;
         RATE_9K6: rate_eff = RATE_9K6;
         default: rate_eff = RATE_20;
      endcase
   end

   // Faster rates trade mains rejection for bandwidth
   assign line_reject = (rate_eff == RATE_10) || (rate_eff == RATE_20);
endmodule
`default_nettype wire

/* rtl/ccfg_func_dec.sv */
/*
 Channel function decoder: raw 4-bit code to effective function.
 Purely combinational, fed from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ccfg_func_dec
   import ccfg_pkg::*;
(
   // Raw field
   input wire logic [ccfg_pkg::FUNC_W-1:0] func_code,
   // Decoded
   output ccfg_pkg::ccfg_func_t func_eff,
   output logic code_defined
);
   always_comb begin
      case (func_code)
         FUNC_HIGH_Z: func_eff = FUNC_HIGH_Z;
         FUNC_VOUT: func_eff = FUNC_VOUT;
         FUNC_IOUT: func_eff = FUNC_IOUT;
         FUNC_VIN: func_eff = FUNC_VIN;
         FUNC_IIN_EXT: func_eff = FUNC_IIN_EXT;
         FUNC_IIN_LOOP: func_eff = FUNC_IIN_LOOP;
         FUNC_RES_2W: func_eff = FUNC_RES_2W;
         FUNC_RES_34W: func_eff = FUNC_RES_34W;
         FUNC_DIN_LOGIC: func_eff = FUNC_DIN_LOGIC;
         FUNC_DIN_LOOP: func_eff = FUNC_DIN_LOOP;
         default: func_eff = FUNC_HIGH_Z;
      endcase
   end

   assign code_defined = (func_eff == func_code);
endmodule
`default_nettype wire

/* rtl/ccfg_regs.sv */
/*
 Channel function select and converter setup registers with their
 decoded outputs and the side-effect strobe to dependent setup registers.
 Assumes the serial interface delivers single-cycle word accesses on
 sys_clk and that conv_active comes from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ccfg_regs
   import ccfg_pkg::*;
#(
   // Converter setup bits 6:0 loaded per function on a function write
   parameter logic [ccfg_pkg::LOW_W*16-1:0] CONV1_LOW_BY_FUNC = '0
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [ccfg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ccfg_pkg::DATA_W-1:0] reg_wdata,
   output logic [ccfg_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rd_valid,
   output logic reg_addr_err,
   // Converter status
   input wire logic conv_active,
   output logic setup_write_busy,
   output logic adc_operational,
   // Decoded channel setup
   output ccfg_pkg::ccfg_func_t channel_function,
   output logic order_violation,
   output ccfg_pkg::ccfg_rate_t first_conversion_rate,
   output ccfg_pkg::ccfg_rate_t second_conversion_rate,
   output ccfg_pkg::ccfg_range_t second_conversion_range,
   output logic conv1_line_reject,
   output logic conv2_line_reject,
   output logic [ccfg_pkg::LOW_W-1:0] conv1_low_field,
   // Side effect toward dependent setup registers
   output logic side_update_pulse,
   output ccfg_pkg::ccfg_func_t side_function
);
   import ccfg_pkg::*;

   logic [FUNC_W-1:0] func_reg;
   logic [FUNC_W-1:0] func_next;
   logic [DATA_W-1:0] conv_reg;
   logic [DATA_W-1:0] conv_next;
   logic [DATA_W-1:0] rdata_next;
   logic seen_reg;

   wire hit_func = (reg_addr == FUNC_SEL_ADDR);
   wire hit_conv = (reg_addr == CONV_SETUP_ADDR);
   wire wr_func = reg_wr_en && hit_func;
   wire wr_conv = reg_wr_en && hit_conv;
   wire rd_func = reg_rd_en && hit_func;
   wire rd_conv = reg_rd_en && hit_conv;
   wire unmapped = (reg_wr_en || reg_rd_en) && !hit_func && !hit_conv;

   // Only the low nibble is stored; upper bits are never kept
   assign func_next = wr_func ? reg_wdata[FUNC_LSB +: FUNC_W] : func_reg;

   ccfg_pkg::ccfg_func_t func_dec_eff;
   wire func_defined;
   ccfg_func_dec u_func_dec (
      .func_code(func_next),
      .func_eff(func_dec_eff),
      .code_defined(func_defined)
   );

   // Dependent low converter field reloaded from the decoded function
   wire [LOW_W-1:0] low_by_func = CONV1_LOW_BY_FUNC[func_dec_eff*LOW_W +: LOW_W];

   always_comb begin
      conv_next = conv_reg;
      if (wr_conv) begin
         conv_next = reg_wdata;
      end else if (wr_func) begin
         conv_next[LOW_LSB +: LOW_W] = low_by_func;
      end
   end

   ccfg_pkg::ccfg_rate_t rate1_eff;
   ccfg_pkg::ccfg_rate_t rate2_eff;
   wire rej1;
   wire rej2;
   ccfg_rate_dec u_rate1_dec (
      .rate_code(conv_next[RATE1_LSB +: RATE_W]),
      .rate_eff(rate1_eff),
      .line_reject(rej1)
   );
   ccfg_rate_dec u_rate2_dec (
      .rate_code(conv_next[RATE2_LSB +: RATE_W]),
      .rate_eff(rate2_eff),
      .line_reject(rej2)
   );

   wire [RANGE_W-1:0] range2_code = conv_next[RANGE2_LSB +: RANGE_W];
   wire range2_listed = (range2_code <= RANGE_0_0V625);
   wire [RANGE_W-1:0] range2_eff = range2_listed ? range2_code : RANGE_0_12V;

   // Hazard flag only; the host owns the off-before-on sequence
   wire order_bad = wr_func && (func_reg != FUNC_HIGH_Z) &&
                    (func_dec_eff != FUNC_HIGH_Z) && (func_next != func_reg);

   assign rdata_next = rd_func ? {RSVD_ZERO, func_reg} :
                       rd_conv ? conv_reg : READ_IDLE;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         func_reg <= FUNC_RESET[FUNC_LSB +: FUNC_W];
         conv_reg <= CONV_RESET;
         seen_reg <= 1'b0;
      end else begin
         func_reg <= func_next;
         conv_reg <= conv_next;
         seen_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= READ_IDLE;
         reg_rd_valid <= 1'b0;
         reg_addr_err <= 1'b0;
      end else begin
         reg_rdata <= rdata_next;
         reg_rd_valid <= reg_rd_en;
         reg_addr_err <= unmapped;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         channel_function <= FUNC_HIGH_Z;
         side_update_pulse <= 1'b0;
         side_function <= FUNC_HIGH_Z;
         order_violation <= 1'b0;
         setup_write_busy <= 1'b0;
      end else begin
         channel_function <= func_dec_eff;
         side_update_pulse <= wr_func;
         side_function <= func_dec_eff;
         order_violation <= order_bad;
         setup_write_busy <= wr_conv && conv_active;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         first_conversion_rate <= RATE_20;
         second_conversion_rate <= RATE_20;
         second_conversion_range <= RANGE_0_12V;
         conv1_line_reject <= 1'b1;
         conv2_line_reject <= 1'b1;
         conv1_low_field <= CONV_RESET[LOW_LSB +: LOW_W];
      end else begin
         first_conversion_rate <= rate1_eff;
         second_conversion_rate <= rate2_eff;
         second_conversion_range <= ccfg_range_t'(range2_eff);
         conv1_line_reject <= rej1;
         conv2_line_reject <= rej2;
         conv1_low_field <= conv_next[LOW_LSB +: LOW_W];
      end
   end

   // No function gates the converter, high impedance included
   assign adc_operational = 1'b1;

   wire [FUNC_W-1:0] wcode = reg_wdata[FUNC_LSB +: FUNC_W];
   wire [RATE_W-1:0] wrate1 = reg_wdata[RATE1_LSB +: RATE_W];
   wire [RATE_W-1:0] wrate2 = reg_wdata[RATE2_LSB +: RATE_W];
   wire [RANGE_W-1:0] wrange2 = reg_wdata[RANGE2_LSB +: RANGE_W];

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   func_reset_a: assert property (!seen_reg |-> func_reg == FUNC_RESET[FUNC_LSB +: FUNC_W] &&
      channel_function == FUNC_HIGH_Z)
      else $error("function not high impedance after reset");
   func_fallback_a: assert property (wr_func && (wcode > FUNC_DIN_LOOP) |=>
      channel_function == FUNC_HIGH_Z)
      else $error("undefined function code not high impedance");
   func_decode_a: assert property (wr_func && (wcode <= FUNC_DIN_LOOP) |=>
      channel_function == $past(wcode))
      else $error("defined function code decoded wrong");
   side_strobe_a: assert property (wr_func |=> side_update_pulse &&
      side_function == channel_function ##1 !side_update_pulse || $past(wr_func))
      else $error("side update strobe missing or wrong");
   order_flag_a: assert property (wr_func && func_reg != FUNC_HIGH_Z && wcode != func_reg &&
      wcode >= FUNC_VOUT && wcode <= FUNC_DIN_LOOP |=> order_violation)
      else $error("direct function change not flagged");
   adc_live_a: assert property (channel_function == FUNC_HIGH_Z |-> adc_operational)
      else $error("converter not operational in high impedance");
   busy_flag_a: assert property (wr_conv && conv_active |=> setup_write_busy)
      else $error("setup change during conversion not flagged");
   rate2_fallback_a: assert property (wr_conv && wrate2 > RATE_9K6 |=>
      second_conversion_rate == RATE_20)
      else $error("unlisted second rate not 20 SPS");
   rate1_decode_a: assert property (wr_conv && wrate1 <= RATE_9K6 |=>
      first_conversion_rate == $past(wrate1))
      else $error("first rate decoded wrong");
   reject_pair_a: assert property (conv1_line_reject == (first_conversion_rate <= RATE_20) &&
      conv2_line_reject == (second_conversion_rate <= RATE_20))
      else $error("line rejection flag wrong");
   range_fallback_a: assert property (wr_conv && wrange2 > RANGE_0_0V625 |=>
      second_conversion_range == RANGE_0_12V)
      else $error("unlisted range not 0 to 12 V");
   range_decode_a: assert property (wr_conv && wrange2 <= RANGE_0_0V625 |=>
      second_conversion_range == $past(wrange2))
      else $error("listed range decoded wrong");
   conv_readback_a: assert property (wr_conv ##1 rd_conv && !reg_wr_en |=>
      reg_rdata == $past(reg_wdata, 2) && reg_rd_valid)
      else $error("converter setup readback wrong");
   rsvd_zero_a: assert property (rd_func |=> reg_rdata[DATA_W-1:FUNC_W] == RSVD_ZERO)
      else $error("reserved function bits not zero");
   code_listed_a: assert property (func_defined == (func_next <= FUNC_DIN_LOOP))
      else $error("function code listing flag wrong");

   func_change_c: cover property (wr_func && wcode == FUNC_HIGH_Z ##[1:20] wr_func &&
      wcode == FUNC_VIN);
   fast_rate_c: cover property (wr_conv && wrate1 == RATE_9K6 ##1 !conv1_line_reject);
   busy_write_c: cover property (setup_write_busy);
endmodule
`default_nettype wire

/* testbench/ccfg_host_model.sv */
/*
 Host side of the register word port, with the converter busy level.
 Assumes the block takes requests at the rising edge of sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module ccfg_host_model (
   // Clock
   input wire logic sys_clk,
   // Register port
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [ccfg_pkg::ADDR_W-1:0] reg_addr,
   output logic [ccfg_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [ccfg_pkg::DATA_W-1:0] reg_rdata,
   input wire logic reg_rd_valid,
   input wire logic reg_addr_err,
   // Converter status
   output logic conv_active
);
   import ccfg_pkg::*;
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 16'h0000;
      conv_active = 1'b0;
   end
   // Idle bus shows inverted values, so stale data never looks valid
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                     output logic v, output logic e);
      @(posedge sys_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
      v = reg_rd_valid;
      e = reg_addr_err;
   endtask
   // Write then read the same word on the very next edge
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                        output logic [DATA_W-1:0] d, output logic v, output logic e);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= wd;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b1;
      reg_wdata <= ~wd;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
      v = reg_rd_valid;
      e = reg_addr_err;
   endtask
   task automatic set_function(input logic [DATA_W-1:0] d);
      wr(FUNC_SEL_ADDR, 16'h0000);
      wr(FUNC_SEL_ADDR, d);
   endtask
   // Converter runs during the write only when a breach is wanted; it is left running afterwards
   task automatic set_conv(input logic [DATA_W-1:0] d, input logic keep_running);
      @(posedge sys_clk);
      conv_active <= keep_running;
      wr(CONV_SETUP_ADDR, d);
      conv_active <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* testbench/ccfg_regs_test.sv */
/*
 Self-checking bench for the function select and converter setup pair.
 Assumes the host model drives all register port inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module ccfg_regs_test;
   import ccfg_pkg::*;
   logic sys_clk;
   logic reset_n;
   logic reg_wr_en, reg_rd_en, reg_rd_valid, reg_addr_err, conv_active;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic setup_write_busy, adc_operational, order_violation, side_update_pulse;
   logic conv1_line_reject, conv2_line_reject;
   logic [LOW_W-1:0] conv1_low_field;
   ccfg_func_t channel_function, side_function;
   ccfg_rate_t first_conversion_rate, second_conversion_rate;
   ccfg_range_t second_conversion_range;
   int errors;
   int total_checks;
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   ccfg_regs ccfg_regs_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_addr_err(reg_addr_err),
      .conv_active(conv_active), .setup_write_busy(setup_write_busy),
      .adc_operational(adc_operational), .channel_function(channel_function),
      .order_violation(order_violation), .first_conversion_rate(first_conversion_rate),
      .second_conversion_rate(second_conversion_rate),
      .second_conversion_range(second_conversion_range),
      .conv1_line_reject(conv1_line_reject), .conv2_line_reject(conv2_line_reject),
      .conv1_low_field(conv1_low_field), .side_update_pulse(side_update_pulse),
      .side_function(side_function));
   ccfg_host_model ccfg_host_model_i (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_addr_err(reg_addr_err),
      .conv_active(conv_active));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic test_reset;
      logic [15:0] d;
      logic v, e;
      chk(16'(channel_function), 16'h0000);
      chk(16'(first_conversion_rate), 16'h0001);
      chk(16'(second_conversion_rate), 16'h0001);
      chk(16'(second_conversion_range), 16'h0000);
      chk({14'h0000, conv1_line_reject, conv2_line_reject}, 16'h0003);
      ccfg_host_model_i.rd(FUNC_SEL_ADDR, d, v, e);
      chk(d, 16'h0000);
      ccfg_host_model_i.rd(CONV_SETUP_ADDR, d, v, e);
      chk(d, 16'h2400);
      chk({14'h0000, v, e}, 16'h0002);
      $display("test_reset done");
   endtask
   task automatic test_functions;
      logic [15:0] d;
      logic v, e;
      logic [3:0] x;
      for (int c = 0; c < 16; c++) begin
         x = (c <= 9) ? 4'(c) : 4'h0;
         ccfg_host_model_i.set_function(16'hfff0 | 16'(c));
         chk(16'(channel_function), 16'(x));
         chk(16'(side_function), 16'(x));
         chk({14'h0000, side_update_pulse, order_violation}, 16'h0002);
         chk({15'h0000, adc_operational}, 16'h0001);
         ccfg_host_model_i.rd(FUNC_SEL_ADDR, d, v, e);
         chk(d, 16'(c));
      end
      // Skipping the high impedance step is flagged
      ccfg_host_model_i.set_function(16'h0001);
      ccfg_host_model_i.wr(FUNC_SEL_ADDR, 16'h0003);
      chk({15'h0000, order_violation}, 16'h0001);
      ccfg_host_model_i.set_function(16'h0000);
      $display("test_functions done");
   endtask
   task automatic test_conv;
      logic [15:0] d, wd;
      logic v, e;
      for (int r = 0; r < 8; r++) begin
         wd = {3'(r), 3'(7 - r), 3'(r), 7'h55};
         ccfg_host_model_i.set_conv(wd, 1'b0);
         chk(16'(second_conversion_rate), (r <= 4) ? 16'(r) : 16'h0001);
         chk(16'(first_conversion_rate), (r >= 3) ? 16'(7 - r) : 16'h0001);
         chk(16'(second_conversion_range), (r <= 5) ? 16'(r) : 16'h0000);
         chk({14'h0000, conv2_line_reject, conv1_line_reject},
             {14'h0000, r <= 1 || r > 4, r >= 6 || r <= 2});
         chk({9'h000, conv1_low_field}, 16'h0055);
         ccfg_host_model_i.rd(CONV_SETUP_ADDR, d, v, e);
         chk(d, wd);
      end
      ccfg_host_model_i.wr_rd(CONV_SETUP_ADDR, 16'h4c80, d, v, e);
      chk(d, 16'h4c80);
      chk({14'h0000, v, e}, 16'h0002);
      ccfg_host_model_i.set_conv(CONV_RESET, 1'b1);
      chk({15'h0000, setup_write_busy}, 16'h0001);
      $display("test_conv done");
   endtask
   task automatic test_unmapped;
      logic [15:0] d;
      logic v, e;
      ccfg_host_model_i.rd(7'h03, d, v, e);
      chk(d, 16'h0000);
      chk({14'h0000, v, e}, 16'h0003);
      $display("test_unmapped done");
   endtask
   initial begin
      errors = 0;
      total_checks = 0;
      reset_n = 1'b0;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      test_reset;
      test_functions;
      test_conv;
      test_unmapped;
      results;
   end
   // Whole run is under two hundred cycles; 4000 leaves ample margin
   initial begin
      #80000;
      errors++;
      results;
   end
endmodule
`default_nettype wire
